/* core/ds3te_line_encoder.sv */
// ds3 transmit line encoder: single-rail nrz or dual-rail ami / b3zs
// assumes framer bits on clk, a free link clock input and axi4-lite access
// Function
// [RULE1] single-rail: whole frame as nrz on positive rail only
// [RULE2] single-rail: negative rail high one bit at each frame start
// [RULE3] dual-rail: frame carried on both rails, ami or b3zs
// [RULE4] dual-rail: positive rail asserted for each positive pulse
// [RULE5] dual-rail: negative rail asserted for each negative pulse
// [RULE6] line clock driven out beside the rails for sampling
// [RULE7] control bit 3: 0 dual-rail, 1 single-rail
// [RULE8] reset leaves the block in dual-rail mode
// [RULE9] rail mode setting also steers the receive side
// [RULE10] ami: each mark takes opposite polarity of previous mark
// [RULE11] ami polarity changes only on marks, never on zeros
// [RULE12] dual-rail zero: both rails low for that bit
// [RULE13] b3zs: every three zeros become 00V or B0V
// [RULE14] B keeps ami alternation, V breaks it
// [RULE15] odd count of B pulses between successive violations
// [RULE16] b3zs otherwise identical to ami
// [RULE17] control bit 4: 0 b3zs, 1 plain ami
// [RULE18] bit 4 ignored in single-rail mode
// [RULE19] control bit 2: update on rising (0) or falling (1) link edge
// [RULE20] exactly one encoded bit per link clock period
// [RULE21] violation pulse counts as previous mark for next polarity
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ds3te_line_encoder #(
    parameter int SYNC_STAGES = 2
) (
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    input  wire logic                         tx_line_clk_in,
    input  wire logic                         tx_data_bit,
    input  wire logic                         tx_frame_start,
    output var  logic                         tx_bit_taken,
    output var  logic                         tx_positive_rail,
    output var  logic                         tx_negative_rail,
    output var  logic                         tx_line_clock_out,
    output var  logic [7:0]                   rx_io_control,
    input  wire logic [ds3te_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output var  logic                         s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output var  logic                         s_axi_wready,
    output var  logic [1:0]                   s_axi_bresp,
    output var  logic                         s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [ds3te_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output var  logic                         s_axi_arready,
    output var  logic [31:0]                  s_axi_rdata,
    output var  logic [1:0]                   s_axi_rresp,
    output var  logic                         s_axi_rvalid,
    input  wire logic                         s_axi_rready
);
    logic [7:0]                   ioctl_reg;
    logic                         aw_free_reg;
    logic                         aw_full_reg;
    logic [ds3te_pkg::ADDR_W-1:0] aw_addr_reg;
    logic                         w_free_reg;
    logic                         w_full_reg;
    logic [7:0]                   w_data_reg;
    logic                         w_strb_reg;
    logic                         ar_free_reg;
    logic [1:0]                   bresp_reg;
    logic                         bvalid_reg;
    logic [31:0]                  rdata_reg;
    logic [1:0]                   rresp_reg;
    logic                         rvalid_reg;
    logic                         commit;
    logic                         link_level;
    logic                         link_rise;
    logic                         link_fall;
    logic                         upd;
    logic                         single_rail;
    logic                         b3zs_on;
    logic                         enc_bit;
    logic                         enc_frame;
    ds3te_pkg::ds3te_tag_e        enc_tag;
    logic                         pos_reg;
    logic                         pos_next;
    logic                         neg_reg;
    logic                         neg_next;
    logic                         last_pos_reg;
    logic                         last_pos_next;
    logic                         parity_reg;
    logic                         parity_next;
    logic                         taken_reg;
    logic                         clk_out_reg;
    ds3te_pkg::ds3te_tag_e        prev_tag_reg;

    if (SYNC_STAGES < 2) begin : g_bad_stages
        $error("ds3te_line_encoder needs SYNC_STAGES >= 2");
    end

    assign single_rail = ioctl_reg[ds3te_pkg::BIT_RAIL];               // RULE7
    assign b3zs_on     = !single_rail && !ioctl_reg[ds3te_pkg::BIT_ZSUB]; // RULE17 RULE18
    // one bit moves per chosen link edge
    assign upd = ioctl_reg[ds3te_pkg::BIT_EDGE] ? link_fall : link_rise; // RULE19 RULE20
    assign commit = aw_full_reg && w_full_reg && !bvalid_reg;

    ds3te_link_sync #(
        .STAGES   (SYNC_STAGES)
    ) u_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .async_in (tx_line_clk_in),
        .level    (link_level),
        .rise     (link_rise),
        .fall     (link_fall)
    );

    ds3te_zero_sub u_zsub (
        .clk       (clk),
        .rst_b     (rst_b),
        .shift_en  (upd),
        .sub_en    (b3zs_on),
        .bit_in    (tx_data_bit),
        .frame_in  (tx_frame_start),
        .out_bit   (enc_bit),
        .out_frame (enc_frame),
        .out_tag   (enc_tag)
    );

    // write address and data are caught independently, either order
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_free_reg <= 1'b0;
            aw_full_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (aw_free_reg && s_axi_awvalid) begin
            aw_free_reg <= 1'b0;
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (commit) begin
            aw_full_reg <= 1'b0;
        end else if (!aw_free_reg && !aw_full_reg && !bvalid_reg) begin
            aw_free_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            w_free_reg <= 1'b0;
            w_full_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= 1'b0;
        end else if (w_free_reg && s_axi_wvalid) begin
            w_free_reg <= 1'b0;
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata[7:0];
            w_strb_reg <= s_axi_wstrb[0];
        end else if (commit) begin
            w_full_reg <= 1'b0;
        end else if (!w_free_reg && !w_full_reg && !bvalid_reg) begin
            w_free_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= ds3te_pkg::RESP_OKAY;
        end else if (commit) begin
            bvalid_reg <= 1'b1;
            if ({aw_addr_reg[ds3te_pkg::ADDR_W-1:2], 2'b00} == ds3te_pkg::IOCTL_ADDR) begin
                bresp_reg <= ds3te_pkg::RESP_OKAY;
            end else if ({aw_addr_reg[ds3te_pkg::ADDR_W-1:2], 2'b00}
                         == ds3te_pkg::STATUS_ADDR) begin
                bresp_reg <= ds3te_pkg::RESP_OKAY;
            end else begin
                bresp_reg <= ds3te_pkg::RESP_SLVERR;
            end
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // the loss-of-clock status bit is read-only and reads zero here
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ioctl_reg <= ds3te_pkg::IOCTL_RESET; // RULE8
        end else if (commit && w_strb_reg
                     && {aw_addr_reg[ds3te_pkg::ADDR_W-1:2], 2'b00}
                        == ds3te_pkg::IOCTL_ADDR) begin
            ioctl_reg <= w_data_reg & ds3te_pkg::IOCTL_WMASK; // RULE7 RULE17 RULE19
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ar_free_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= '0;
            rresp_reg   <= ds3te_pkg::RESP_OKAY;
        end else if (ar_free_reg && s_axi_arvalid) begin
            ar_free_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            if ({s_axi_araddr[ds3te_pkg::ADDR_W-1:2], 2'b00} == ds3te_pkg::IOCTL_ADDR) begin
                rdata_reg <= {24'h000000, ioctl_reg};
                rresp_reg <= ds3te_pkg::RESP_OKAY;
            end else if ({s_axi_araddr[ds3te_pkg::ADDR_W-1:2], 2'b00}
                         == ds3te_pkg::STATUS_ADDR) begin
                rdata_reg <= {29'h0, link_level, parity_reg, last_pos_reg};
                rresp_reg <= ds3te_pkg::RESP_OKAY;
            end else begin
                rdata_reg <= '0;
                rresp_reg <= ds3te_pkg::RESP_SLVERR;
            end
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end else if (!ar_free_reg && !rvalid_reg) begin
            ar_free_reg <= 1'b1;
        end
    end

    // line coding of the oldest bit in the look-ahead line
    always_comb begin
        pos_next      = pos_reg;
        neg_next      = neg_reg;
        last_pos_next = last_pos_reg;
        parity_next   = parity_reg;
        if (upd) begin
            if (single_rail) begin
                pos_next = enc_bit;   // RULE1
                neg_next = enc_frame; // RULE2
            end else if (b3zs_on && enc_tag == ds3te_pkg::DS3TE_TAG_V) begin
                // violation repeats the last polarity and restarts the count
                pos_next    = last_pos_reg;  // RULE14 RULE4
                neg_next    = !last_pos_reg; // RULE14 RULE5
                parity_next = 1'b0;          // RULE15 RULE21
            end else if (b3zs_on && enc_tag == ds3te_pkg::DS3TE_TAG_B) begin
                if (parity_reg) begin // RULE15
                    pos_next = 1'b0;
                    neg_next = 1'b0;
                end else begin
                    pos_next      = !last_pos_reg; // RULE14
                    neg_next      = last_pos_reg;
                    last_pos_next = !last_pos_reg;
                    parity_next   = 1'b1;
                end
            end else if (b3zs_on && enc_tag == ds3te_pkg::DS3TE_TAG_ZERO) begin
                pos_next = 1'b0;
                neg_next = 1'b0;
            end else if (enc_bit) begin
                pos_next      = !last_pos_reg; // RULE10 RULE16 RULE3 RULE4
                neg_next      = last_pos_reg;  // RULE10 RULE5
                last_pos_next = !last_pos_reg;
                parity_next   = !parity_reg;
            end else begin
                pos_next = 1'b0; // RULE12 RULE11
                neg_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pos_reg      <= 1'b0;
            neg_reg      <= 1'b0;
            last_pos_reg <= 1'b0;
            parity_reg   <= 1'b0;
        end else begin
            pos_reg      <= pos_next;
            neg_reg      <= neg_next;
            last_pos_reg <= last_pos_next;
            parity_reg   <= parity_next;
        end
    end

    // clock out follows the synced level so rails and clock share a delay
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_out_reg <= 1'b0;
            taken_reg   <= 1'b0;
        end else begin
            clk_out_reg <= link_level; // RULE6
            taken_reg   <= upd;        // RULE20
        end
    end

    assign tx_positive_rail  = pos_reg;
    assign tx_negative_rail  = neg_reg;
    assign tx_line_clock_out = clk_out_reg;
    assign tx_bit_taken      = taken_reg;
    assign rx_io_control     = ioctl_reg; // RULE9
    assign s_axi_awready     = aw_free_reg;
    assign s_axi_wready      = w_free_reg;
    assign s_axi_bvalid      = bvalid_reg;
    assign s_axi_bresp       = bresp_reg;
    assign s_axi_arready     = ar_free_reg;
    assign s_axi_rvalid      = rvalid_reg;
    assign s_axi_rdata       = rdata_reg;
    assign s_axi_rresp       = rresp_reg;

    // tag encoded at the previous update, lets the run order be checked per bit
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_tag_reg <= ds3te_pkg::DS3TE_TAG_NONE;
        end else if (upd) begin
            prev_tag_reg <= enc_tag;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_single_nrz_pos: // RULE1
        assert property (upd && single_rail |=> tx_positive_rail == $past(enc_bit))
        else $error("single-rail positive rail not carrying data");
    a_marker_low: // RULE2
        assert property (upd && single_rail && !enc_frame |=> !tx_negative_rail)
        else $error("frame marker high outside frame start");
    a_rails_exclusive: // RULE3
        assert property (upd && !single_rail |=> !(tx_positive_rail && tx_negative_rail))
        else $error("both rails high in dual-rail mode");
    a_ami_alternates: // RULE10
        assert property (upd && !single_rail && enc_bit
                         && (!b3zs_on || enc_tag == ds3te_pkg::DS3TE_TAG_NONE)
                         |=> tx_positive_rail != $past(last_pos_reg)
                             && tx_negative_rail == $past(last_pos_reg))
        else $error("mark polarity did not alternate");
    a_zero_holds_pol: // RULE11
        assert property (upd && !enc_bit && enc_tag == ds3te_pkg::DS3TE_TAG_NONE
                         |=> $stable(last_pos_reg))
        else $error("zero bit changed mark polarity");
    a_space_quiet: // RULE12
        assert property (upd && !single_rail && !enc_bit
                         && enc_tag == ds3te_pkg::DS3TE_TAG_NONE
                         |=> !tx_positive_rail && !tx_negative_rail)
        else $error("zero bit drove a rail");
    a_viol_polarity: // RULE14
        assert property (upd && b3zs_on && enc_tag == ds3te_pkg::DS3TE_TAG_V
                         |=> tx_positive_rail == $past(last_pos_reg)
                             && tx_negative_rail != $past(last_pos_reg))
        else $error("violation pulse has wrong polarity");
    a_odd_b_count: // RULE15
        assert property (upd && b3zs_on && enc_tag == ds3te_pkg::DS3TE_TAG_V
                         |-> parity_reg ##1 !parity_reg)
        else $error("even pulse count before violation");
    a_sub_sequence: // RULE13
        assert property (upd && b3zs_on && (enc_tag == ds3te_pkg::DS3TE_TAG_ZERO
                         || enc_tag == ds3te_pkg::DS3TE_TAG_V)
                         |-> prev_tag_reg == ((enc_tag == ds3te_pkg::DS3TE_TAG_V)
                             ? ds3te_pkg::DS3TE_TAG_ZERO : ds3te_pkg::DS3TE_TAG_B))
        else $error("substitution run out of order");
    a_rails_on_edge: // RULE19
        assert property ($changed(tx_positive_rail) || $changed(tx_negative_rail)
                         |-> $past(upd))
        else $error("rail changed away from selected edge");
    a_one_per_period: // RULE20
        assert property (upd |=> tx_bit_taken ##1 !tx_bit_taken)
        else $error("bit taken pulse not one cycle per edge");
    a_reset_dual: // RULE8
        assert property ($past(!rst_b) |-> !single_rail)
        else $error("block left reset in single-rail mode");
    a_shared_mode: // RULE9
        assert property (rx_io_control[ds3te_pkg::BIT_RAIL] == single_rail)
        else $error("receive side sees different rail mode");

    c_b0v: cover property (upd && b3zs_on && enc_tag == ds3te_pkg::DS3TE_TAG_B
                           && !parity_reg);
    c_00v: cover property (upd && b3zs_on && enc_tag == ds3te_pkg::DS3TE_TAG_B
                           && parity_reg);
    c_marker: cover property (single_rail && tx_negative_rail);
    c_write: cover property (commit && w_strb_reg);
endmodule : ds3te_line_encoder
`default_nettype wire

/* core/ds3te_link_sync.sv */
// synchroniser and edge finder for the incoming transmit line clock
// assumes the link clock is far slower than clk
`timescale 1ns/1ps
`default_nettype none
module ds3te_link_sync #(
    parameter int STAGES = 2
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic async_in,
    output var  logic level,
    output var  logic rise,
    output var  logic fall
);
    logic [STAGES-1:0] sync_reg;
    logic              level_d_reg;
    logic [STAGES:0]   primed_reg;

    if (STAGES < 2) begin : g_bad_stages
        $error("ds3te_link_sync needs two stages");
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_reg    <= '0;
            level_d_reg <= 1'b0;
            primed_reg  <= '0;
        end else begin
            sync_reg    <= {sync_reg[STAGES-2:0], async_in};
            level_d_reg <= sync_reg[STAGES-1];
            primed_reg  <= {primed_reg[STAGES-1:0], 1'b1};
        end
    end

    // no false edge from reset zeros; a real edge right after reset is lost
    assign level = sync_reg[STAGES-1];
    assign rise  = primed_reg[STAGES] & sync_reg[STAGES-1] & ~level_d_reg;
    assign fall  = primed_reg[STAGES] & ~sync_reg[STAGES-1] & level_d_reg;
endmodule : ds3te_link_sync
`default_nettype wire

/* core/ds3te_pkg.sv */
// constants shared by the ds3 transmit line encoder files
// assumes a 32-bit axi4-lite register bus and a 3-zero substitution window
package ds3te_pkg;
    localparam int          ADDR_W       = 8;
    localparam int          IOCTL_INDEX  = 1;
    localparam int          STATUS_INDEX = 2;
    localparam logic [7:0]  IOCTL_ADDR   = 8'(IOCTL_INDEX * 4);
    localparam logic [7:0]  STATUS_ADDR  = 8'(STATUS_INDEX * 4);
    localparam logic [7:0]  IOCTL_RESET  = 8'hA0;
    localparam logic [7:0]  IOCTL_WMASK  = 8'hBF;
    localparam int          BIT_ZSUB     = 4;
    localparam int          BIT_RAIL     = 3;
    localparam int          BIT_EDGE     = 2;
    localparam int          ZERO_RUN     = 3;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    typedef enum logic [1:0] {
        DS3TE_TAG_NONE = 2'b00,
        DS3TE_TAG_B    = 2'b01,
        DS3TE_TAG_ZERO = 2'b10,
        DS3TE_TAG_V    = 2'b11
    } ds3te_tag_e;
endpackage : ds3te_pkg

/* core/ds3te_zero_sub.sv */
// look-ahead delay line that marks runs of three zeros for substitution
// assumes shift_en pulses once per line bit
`timescale 1ns/1ps
`default_nettype none
module ds3te_zero_sub (
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic                  shift_en,
    input  wire logic                  sub_en,
    input  wire logic                  bit_in,
    input  wire logic                  frame_in,
    output var  logic                  out_bit,
    output var  logic                  out_frame,
    output var  ds3te_pkg::ds3te_tag_e out_tag
);
    localparam int N = ds3te_pkg::ZERO_RUN;
    logic                  bit_q   [N];
    logic                  frame_q [N];
    ds3te_pkg::ds3te_tag_e tag_q   [N];
    logic                  run_hit;

    // a new run needs two untagged zeros already waiting plus the new zero
    assign run_hit = sub_en && !bit_in && !bit_q[0] && !bit_q[1]
                     && tag_q[0] == ds3te_pkg::DS3TE_TAG_NONE
                     && tag_q[1] == ds3te_pkg::DS3TE_TAG_NONE;

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_stage
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    bit_q[i]   <= 1'b0;
                    frame_q[i] <= 1'b0;
                    tag_q[i]   <= ds3te_pkg::DS3TE_TAG_NONE;
                end else if (shift_en) begin
                    bit_q[i]   <= (i == 0) ? bit_in   : bit_q[(i == 0) ? 0 : i-1];
                    frame_q[i] <= (i == 0) ? frame_in : frame_q[(i == 0) ? 0 : i-1];
                    if (run_hit) begin // RULE13
                        tag_q[i] <= (i == 0) ? ds3te_pkg::DS3TE_TAG_V :
                                    (i == 1) ? ds3te_pkg::DS3TE_TAG_ZERO :
                                               ds3te_pkg::DS3TE_TAG_B;
                    end else begin
                        tag_q[i] <= (i == 0) ? ds3te_pkg::DS3TE_TAG_NONE
                                             : tag_q[(i == 0) ? 0 : i-1];
                    end
                end
            end
        end
    endgenerate

    assign out_bit   = bit_q[N-1];
    assign out_frame = frame_q[N-1];
    assign out_tag   = tag_q[N-1];
endmodule : ds3te_zero_sub
`default_nettype wire

/* sim/ds3_tx_line_encoder_tb_top.sv */
// bench for the ds3 transmit line encoder: registers and line code per mode
// assumes the unit model makes the line clock
`timescale 1ns/1ps
`default_nettype none
module ds3_tx_line_encoder_tb_top;
    localparam logic [63:0] PAT = 64'h8F10_2008_4A01_0013;
    localparam int          NB  = 60;
    logic        clk = 0, rst_b = 0, tx_data_bit = 0, tx_frame_start = 0, edge_sel = 0;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, rx_io_control;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_bit_taken, tx_line_clk_in;
    logic        tx_positive_rail, tx_negative_rail, tx_line_clock_out;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r, rec[$];
    logic signed [1:0] line_level;
    logic [31:0] d;
    int          n_errors = 0, tests_run = 0, kbit = 0;

    ds3te_line_encoder dut_u (.*);
    ds3te_liu_model liu_u (.*);

    initial begin
        forever #2.5 clk = ~clk;
    end

    function automatic logic signed [1:0] lvl(input logic [1:0] x);
        return x[1] ? 2'sd1 : (x[0] ? -2'sd1 : 2'sd0);
    endfunction : lvl

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic final_report();
        if (n_errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report

    task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            rs = s_axi_bresp;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            v = s_axi_rdata;
            rs = s_axi_rresp;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask : axi_read

    // framer side: next bit after each take; early bits skipped while mode settles
    always @(posedge clk) begin
        if (rst_b && tx_bit_taken) begin
            rec.push_back({tx_positive_rail, tx_negative_rail});
            if (kbit > 4) begin
                check("phase", 32'(tx_line_clock_out), 32'(!edge_sel));
                check("level", 32'(line_level), 32'(lvl(rec[kbit-1])));
            end
        end
        kbit = rst_b ? kbit + int'(tx_bit_taken) : 0;
        tx_data_bit <= PAT[kbit%64];
        tx_frame_start <= kbit % 10 == 0;
    end

    task automatic run(input logic [7:0] c);
        logic signed [1:0] lp, p;
        bit                isv [256];
        int                nb, zr;
        bit                sv;
        @(posedge clk);
        rst_b <= 1'b0;
        edge_sel <= c[2];
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rec.delete();
        if (c == 8'hA0) begin
            axi_read(ds3te_pkg::IOCTL_ADDR, d, r);
            check("ioctl", d, 32'hA0);
            check("rx_copy", 32'(rx_io_control), 32'hA0);
        end else axi_write(ds3te_pkg::IOCTL_ADDR, 32'(c), r);
        while (rec.size() < NB) @(posedge clk);
        lp = 0; nb = 0; zr = 0; sv = 0;
        foreach (rec[j]) begin
            p = lvl(rec[j]);
            isv[j] = !c[3] && p != 0 && p == lp;
            if (j > 4 && !c[3]) begin
                check("pair", 32'(&rec[j]), 0);
                if (c[4]) check("ami", 32'(isv[j]), 0);
                else begin
                    zr = p == 0 ? zr + 1 : 0;
                    check("zrun", 32'(zr > 2), 0);
                    if (isv[j]) check("bv", 32'(rec[j-1] == 0 && (!sv || nb[0])), 1);
                end
            end
            if (isv[j]) begin
                nb = 0;
                sv = j > 4;
            end else if (p != 0) nb++;
            if (p != 0) lp = p;
        end
        for (int k = 2; k < NB - 6; k++) begin
            if (c[3]) check("nrz", 32'(rec[k+3]), 32'({PAT[k], k % 10 == 0}));
            else check("data", 32'(rec[k+3] != 0 && !isv[k+3] && !isv[k+5]), 32'(PAT[k]));
        end
    endtask : run

    initial begin
        run(8'hA0);
        run(8'hB0);
        run(8'hB4);
        run(8'hA8);
        run(8'hBC);
        axi_write(ds3te_pkg::IOCTL_ADDR, 32'hFFFF_FFFF, r);
        check("bresp", 32'(r), 32'(ds3te_pkg::RESP_OKAY));
        axi_read(ds3te_pkg::IOCTL_ADDR, d, r);
        check("ioctl_rw", d, 32'hBF);
        check("rx_copy", 32'(rx_io_control), 32'hBF);
        axi_read(8'h10, d, r);
        check("unmapped", {d[29:0], r}, {30'h0, ds3te_pkg::RESP_SLVERR});
        axi_read(ds3te_pkg::STATUS_ADDR, d, r);
        check("status", {d[31:3], 1'b0, r}, {29'h0, 1'b0, ds3te_pkg::RESP_OKAY});
        final_report();
    end

    initial begin
        #100_000;
        n_errors++;
        final_report();
    end
endmodule : ds3_tx_line_encoder_tb_top
`default_nettype wire

/* sim/ds3te_liu_model.sv */
// line interface unit model: makes the line clock, samples the rails mid-bit
// assumes the encoder returns the line clock beside its rails
`timescale 1ns/1ps
`default_nettype none
module ds3te_liu_model (
    input  wire logic              edge_sel,
    input  wire logic              tx_positive_rail,
    input  wire logic              tx_negative_rail,
    input  wire logic              tx_line_clock_out,
    output var  logic              tx_line_clk_in,
    output var  logic signed [1:0] line_level
);
    initial begin
        tx_line_clk_in = 1'b0;
        forever #62.5 tx_line_clk_in = ~tx_line_clk_in;
    end
    // opposite edge to the update edge, so the rails are settled
    always @(tx_line_clock_out) begin
        if (tx_line_clock_out === edge_sel) begin
            line_level <= tx_positive_rail ? 2'sd1 : (tx_negative_rail ? -2'sd1 : 2'sd0);
        end
    end
endmodule : ds3te_liu_model
`default_nettype wire
